//--- logic/wtu_top.sv
// Watchdog timer unit: control and status registers, slow-clock prescaler
// counter, sleep tracking, timeout reset and wake generation.
// Assumes sleep, clear, oscillator-fail and start-up inputs are synchronous.
//
// How it works
// R1: Soft mode runs only while enable bit set
// R2: Enable bit ignored in modes 00, 1x
// R3: Sleep never changes activity in soft mode
// R4: Counter held clear when mode off
// R5: Five-bit period field sets timeout interval
// R6: Period field resets to code 01011
// R7: Code 0 is 1:32, each step doubles
// R8: Reserved codes act as 1:32 minimum
// R9: Clear on reset, instruction, sleep, faults, start-up
// R10: Sleep entry clears; counting resumes if enabled
// R11: Crystal wake holds clear through start-up timer
// R12: Timeout in sleep wakes, never resets
// R13: Timeout updates timeout, powerdown, reset flags
// R14: Oscillator divider changes leave counter alone
// R15: Time base is slow internal oscillator
// R16: Control bits 7 and 6 read zero
// R17: Mode 11 active always, sleep included
// R18: Mode 10 active awake, off in sleep
// R19: Awake expiry forces a device reset
// R20: Timeout is single-cycle pulse on terminal count
// R21: Field changes safe; cleared counter restarts zero
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module wtu_top
   import wtu_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_slow_osc,
   input wire logic [1:0] i_watchdog_mode_config,
   input wire logic i_watchdog_clear_instr,
   input wire logic i_sleep,
   input wire logic i_osc_fail,
   input wire logic i_osc_startup_timer,
   input wire logic i_crystal_clock,
   input wire wtu_bus_req_t i_bus,
   output logic [DATA_W-1:0] o_rdata,
   output logic o_watchdog_reset,
   output logic o_wake,
   output logic o_timeout_status_flag_n,
   output logic o_powerdown_flag_n,
   output logic o_watchdog_reset_flag_n,
   output logic o_active
);

   // ----------------------------------------------------------------
   // Slow oscillator tick
   // ----------------------------------------------------------------
   logic osc_sync;
   logic osc_prev_q;
   logic tick_w;

   // The slow oscillator is sampled, never used as a clock [R15]
   wtu_sync2 #(.WIDTH(1)) u_osc_sync (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_async(i_slow_osc),
      .o_sync(osc_sync)
   );

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         osc_prev_q <= 1'b0;
      end else begin
         osc_prev_q <= osc_sync;
      end
   end

   assign tick_w = osc_sync & ~osc_prev_q; // [R15]

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] ctrl_q;
   logic [DATA_W-1:0] ctrl_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [DATA_W-1:0] stat_w;
   logic wr_ctrl_w;
   logic wr_stat_w;
   logic [PS_W-1:0] ps_w;
   logic swen_w;
   logic asleep_to_w;
   logic awake_to_w;

   assign wr_ctrl_w = i_bus.wr && (i_bus.addr == CTRL_IDX);
   assign wr_stat_w = i_bus.wr && (i_bus.addr == STAT_IDX);
   assign ps_w = ctrl_q[PS_POS +: PS_W];
   assign swen_w = ctrl_q[SWEN_POS];

   // Bits 7:6 are never stored, so they cannot read back as one [R16]
   assign ctrl_d = awake_to_w ? CTRL_RST :
                   wr_ctrl_w ? {2'h0, i_bus.wdata[5:0]} : ctrl_q; // [R5] [R6]

   assign stat_w = {5'h00, ~o_watchdog_reset_flag_n, ~o_powerdown_flag_n,
                    ~o_timeout_status_flag_n};

   assign rdata_d = !i_bus.rd ? 8'h00 :
                    (i_bus.addr == CTRL_IDX) ? ctrl_q :
                    (i_bus.addr == STAT_IDX) ? stat_w : 8'h00; // [R16]

   // Own-timeout reload stands in for the device reset it triggers [R6]
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_q <= CTRL_RST; // [R6]
         rdata_q <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Sleep tracking
   // ----------------------------------------------------------------
   wtu_state_t state_q;
   wtu_state_t state_d;
   logic sleep_enter_w;
   logic sleep_exit_w;

   assign sleep_enter_w = (state_q == ST_AWAKE) && i_sleep;
   assign sleep_exit_w = (state_q == ST_ASLEEP) && !i_sleep;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_AWAKE: begin
            if (i_sleep) begin
               state_d = ST_ASLEEP;
            end
         end
         ST_ASLEEP: begin
            if (!i_sleep) begin
               state_d = i_crystal_clock ? ST_OST_HOLD : ST_AWAKE; // [R11]
            end
         end
         ST_OST_HOLD: begin
            if (!i_osc_startup_timer) begin
               state_d = ST_AWAKE;
            end
         end
         default: begin
            state_d = ST_AWAKE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= ST_AWAKE;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Activity and clearing
   // ----------------------------------------------------------------
   logic active_w;
   logic clear_w;

   // Soft mode looks at the enable bit only; other modes ignore it
   assign active_w = (i_watchdog_mode_config == MODE_ALWAYS) || // [R17] [R2]
                     ((i_watchdog_mode_config == MODE_NO_SLEEP) && !i_sleep) || // [R18]
                     ((i_watchdog_mode_config == MODE_SOFT) && swen_w); // [R1] [R3]

   assign clear_w = !active_w || // [R4]
                    i_watchdog_clear_instr || i_osc_fail || // [R9]
                    sleep_enter_w || sleep_exit_w || // [R10]
                    (state_q == ST_OST_HOLD) || i_osc_startup_timer; // [R11]

   // ----------------------------------------------------------------
   // Prescaler counter
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [4:0] shift_w;
   logic [TERM_W-1:0] term_m1_w;
   logic expire_w;

   // Reserved codes fold onto the shortest interval [R7] [R8]
   assign shift_w = (ps_w <= PS_MAX) ? 5'(ps_w + MIN_SHIFT) : MIN_SHIFT;
   assign term_m1_w = (24'h000001 << shift_w) - 24'h000001;

   // Greater-or-equal keeps a shortened period from wrapping past it [R21]
   assign expire_w = active_w && !clear_w && tick_w &&
                     ({1'b0, cnt_q} >= term_m1_w); // [R20]

   // The counter only advances on slow ticks, so divider changes of the
   // system clock never touch it [R14]
   assign cnt_d = (clear_w || expire_w) ? '0 :
                  tick_w ? CNT_W'(cnt_q + 23'h000001) : cnt_q; // [R21]

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_q <= '0; // [R9]
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // ----------------------------------------------------------------
   // Timeout outcome and flags
   // ----------------------------------------------------------------
   logic to_n_q;
   logic pd_n_q;
   logic wr_n_q;
   logic reset_q;
   logic wake_q;
   logic active_q;

   assign asleep_to_w = expire_w && i_sleep; // [R12]
   assign awake_to_w = expire_w && !i_sleep; // [R19]

   // Flag events win over clears in the same cycle
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         to_n_q <= 1'b1;
         pd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         reset_q <= 1'b0;
         wake_q <= 1'b0;
         active_q <= 1'b0;
      end else begin
         to_n_q <= expire_w ? 1'b0 :
                   (i_watchdog_clear_instr ||
                    (wr_stat_w && i_bus.wdata[STAT_TO_POS])) ? 1'b1 : to_n_q; // [R13]
         pd_n_q <= asleep_to_w ? 1'b0 :
                   (i_watchdog_clear_instr ||
                    (wr_stat_w && i_bus.wdata[STAT_PD_POS])) ? 1'b1 : pd_n_q; // [R13]
         wr_n_q <= awake_to_w ? 1'b0 :
                   (wr_stat_w && i_bus.wdata[STAT_WR_POS]) ? 1'b1 : wr_n_q; // [R13]
         reset_q <= awake_to_w; // [R19]
         wake_q <= asleep_to_w; // [R12]
         active_q <= active_w;
      end
   end

   assign o_rdata = rdata_q;
   assign o_watchdog_reset = reset_q;
   assign o_wake = wake_q;
   assign o_timeout_status_flag_n = to_n_q;
   assign o_powerdown_flag_n = pd_n_q;
   assign o_watchdog_reset_flag_n = wr_n_q;
   assign o_active = active_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);

   property p_soft_off;
      (i_watchdog_mode_config == MODE_SOFT) && !swen_w |=> cnt_q == '0;
   endproperty
   a_soft_off: assert property (p_soft_off) else $error("soft mode off but counting"); // [R1]

   property p_mode_off;
      (i_watchdog_mode_config == MODE_OFF) |=> (cnt_q == '0) && !o_active;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("mode off but counting"); // [R4]

   property p_ignore_en;
      i_watchdog_mode_config[1] |=> o_active == ($past(i_watchdog_mode_config) == MODE_ALWAYS
                                                || !$past(i_sleep));
   endproperty
   a_ignore_en: assert property (p_ignore_en) else $error("enable bit affected mode 1x"); // [R2]

   property p_soft_sleep;
      (i_watchdog_mode_config == MODE_SOFT) |=> o_active == $past(swen_w);
   endproperty
   a_soft_sleep: assert property (p_soft_sleep) else $error("soft activity wrong"); // [R3]

   property p_reset_default;
      o_watchdog_reset |-> ctrl_q[PS_POS +: PS_W] == PS_DEFAULT;
   endproperty
   a_reset_default: assert property (p_reset_default) else $error("period not reset"); // [R6]

   property p_min_period;
      expire_w && ((ps_w == 5'h00) || (ps_w > PS_MAX)) |-> cnt_q == 23'h00001F;
   endproperty
   a_min_period: assert property (p_min_period) else $error("minimum period wrong"); // [R8]

   property p_default_period;
      expire_w && (ps_w == PS_DEFAULT) |-> cnt_q == 23'h00FFFF;
   endproperty
   a_default_period: assert property (p_default_period) else $error("1:65536 wrong"); // [R7]

   property p_clear_instr;
      i_watchdog_clear_instr |=> cnt_q == '0;
   endproperty
   a_clear_instr: assert property (p_clear_instr) else $error("clear ignored"); // [R9]

   property p_sleep_entry;
      sleep_enter_w |=> cnt_q == '0;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry kept count"); // [R10]

   property p_ost_hold;
      (state_q == ST_OST_HOLD) |=> cnt_q == '0;
   endproperty
   a_ost_hold: assert property (p_ost_hold) else $error("count during start-up"); // [R11]

   property p_sleep_no_reset;
      o_watchdog_reset |-> $past(!i_sleep) && !o_wake;
   endproperty
   a_sleep_no_reset: assert property (p_sleep_no_reset) else $error("reset in sleep"); // [R12]

   property p_flags;
      o_watchdog_reset |-> !o_timeout_status_flag_n && !o_watchdog_reset_flag_n
                           && o_powerdown_flag_n == $past(pd_n_q);
   endproperty
   a_flags: assert property (p_flags) else $error("flags not updated"); // [R13]

   property p_pulse;
      o_watchdog_reset |=> !o_watchdog_reset;
   endproperty
   a_pulse: assert property (p_pulse) else $error("reset not a pulse"); // [R20]

   property p_rsvd_bits;
      o_rdata[7:6] == 2'h0;
   endproperty
   a_rsvd_bits: assert property (p_rsvd_bits) else $error("bits 7:6 not zero"); // [R16]

   c_awake_to: cover property (o_watchdog_reset);
   c_sleep_to: cover property (o_wake);
   c_ost_hold: cover property (state_q == ST_OST_HOLD);
   c_ctrl_wr: cover property (wr_ctrl_w ##1 i_bus.rd && i_bus.addr == CTRL_IDX);

endmodule

//--- logic/wtu_pkg.sv
// Shared constants and carrier types of the watchdog timer unit.
// Assumes one system clock; the slow oscillator arrives as a plain pin.
package wtu_pkg;

   // ----------------------------------------------------------------
   // Register map and layout
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_IDX = 4'h0;
   localparam logic [ADDR_W-1:0] STAT_IDX = 4'h1;
   localparam int unsigned SWEN_POS = 0;
   localparam int unsigned PS_POS = 1;
   localparam int unsigned PS_W = 5;
   localparam int unsigned STAT_TO_POS = 0;
   localparam int unsigned STAT_PD_POS = 1;
   localparam int unsigned STAT_WR_POS = 2;
   localparam logic [DATA_W-1:0] CTRL_RST = 8'h16;
   localparam logic [PS_W-1:0] PS_DEFAULT = 5'h0B;
   localparam logic [PS_W-1:0] PS_MAX = 5'h12;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned SLOW_OSC_KHZ = 31;
   localparam int unsigned SYS_CLK_MHZ = 100;
   localparam logic [4:0] MIN_SHIFT = 5'h05;
   localparam int unsigned CNT_W = 23;
   localparam int unsigned TERM_W = CNT_W + 1;

   // ----------------------------------------------------------------
   // Modes and states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_OFF = 2'h0,
      MODE_SOFT = 2'h1,
      MODE_NO_SLEEP = 2'h2,
      MODE_ALWAYS = 2'h3
   } wtu_mode_t;

   typedef enum logic [2:0] {
      ST_AWAKE = 3'h1,
      ST_ASLEEP = 3'h2,
      ST_OST_HOLD = 3'h4
   } wtu_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } wtu_bus_req_t;

endpackage

//--- logic/wtu_sync2.sv
// Two flip-flop synchroniser for levels arriving from outside the clock.
// Assumes the source is slow against the system clock.
`timescale 1ns/10ps
module wtu_sync2 #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;

endmodule

//--- test/wtu_tb.sv
// Self-checking bench for the watchdog timer unit.
// Assumes wtu_pkg and wtu_top are compiled first; runs on one clock.
`timescale 1ns/10ps
module testbench
   import wtu_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic osc = 1'b0;
   logic [1:0] mode = 2'h0;
   logic clr = 1'b0;
   logic sleep = 1'b0;
   logic fail = 1'b0;
   logic osc_startup_timer = 1'b0;
   logic xtal = 1'b0;
   wtu_bus_req_t bus = '0;
   logic [DATA_W-1:0] rdata;
   logic wdr, wake, to_n, pd_n, rf_n, active;
   logic [7:0] rd_q[$];
   logic [1:0] evt_q[$];
   logic [7:0] exp8;
   logic [7:0] rnd = 8'h36;
   logic rd_seen = 1'b0;
   int err_total = 0;
   int comparisons = 0;
   int cyc = 0;
   int div = 0;
   localparam logic [1:0] EV_RST = 2'h1;
   localparam logic [1:0] EV_WAKE = 2'h2;

   wtu_top wtu_top_i (
      .i_clk_sys(clk), .i_rstn(rstn), .i_slow_osc(osc),
      .i_watchdog_mode_config(mode), .i_watchdog_clear_instr(clr),
      .i_sleep(sleep), .i_osc_fail(fail), .i_osc_startup_timer(osc_startup_timer),
      .i_crystal_clock(xtal), .i_bus(bus), .o_rdata(rdata),
      .o_watchdog_reset(wdr), .o_wake(wake),
      .o_timeout_status_flag_n(to_n), .o_powerdown_flag_n(pd_n),
      .o_watchdog_reset_flag_n(rf_n), .o_active(active)
   );

   // ----------------------------------------------------------------
   // Clocks; slow oscillator sped up to 20 cycles a tick to keep runs short
   // ----------------------------------------------------------------
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (div == 9) begin
         div <= 0;
         osc <= ~osc;
      end else begin
         div <= div + 1;
      end
   end

   // ----------------------------------------------------------------
   // Compare and closing tasks
   // ----------------------------------------------------------------
   task automatic chk_data(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_evt(input string nm, input logic [1:0] e, input logic [1:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_lvl(input string nm, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Drivers
   // ----------------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      @(posedge clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus <= '0;
   endtask
   task automatic kick();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask
   // Waits for a noted pulse; too early or too late is a mismatch
   task automatic expect_evt(input logic [1:0] k, input int lo, input int hi);
      int n;
      n = 0;
      evt_q.push_back(k);
      while (evt_q.size() != 0 && n < hi) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_lvl("pulse_in_window", 1'b1, evt_q.size() == 0 && n >= lo);
      evt_q.delete();
   endtask

   // ----------------------------------------------------------------
   // Monitor: pops the oldest note whenever a result appears
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (rd_seen) begin
         exp8 = rd_q.pop_front();
         chk_data("rdata", exp8, rdata);
      end
      rd_seen = bus.rd & rstn;
      if (wdr === 1'b1 || wake === 1'b1) begin
         if (evt_q.size() == 0) begin
            chk_evt("pulse", 2'h0, {wake, wdr});
         end else begin
            chk_evt("pulse", evt_q.pop_front(), {wake, wdr});
         end
      end
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         end_sim();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      idle(8);
      rstn <= 1'b1;
      rd(CTRL_IDX, CTRL_RST);
      rd(STAT_IDX, 8'h00);
      rd(4'h5, 8'h00);
      wr(CTRL_IDX, 8'hFF);
      rd(CTRL_IDX, 8'h3F);
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         wr(CTRL_IDX, rnd);
         rd(CTRL_IDX, rnd & 8'h3F);
      end
      wr(4'h9, 8'hAA);
      rd(CTRL_IDX, rnd & 8'h3F);
      // Mode off with enable set: no pulse, never active
      wr(CTRL_IDX, 8'h01);
      idle(800);
      chk_lvl("active", 1'b0, active);
      // Soft mode: off with enable clear, then runs
      @(posedge clk);
      mode <= 2'h1;
      wr(CTRL_IDX, 8'h00);
      idle(800);
      chk_lvl("active", 1'b0, active);
      wr(CTRL_IDX, 8'h01);
      kick();
      expect_evt(EV_RST, 600, 680);
      chk_lvl("to_n", 1'b0, to_n);
      chk_lvl("rf_n", 1'b0, rf_n);
      chk_lvl("pd_n", 1'b1, pd_n);
      rd(STAT_IDX, 8'h05);
      wr(STAT_IDX, 8'h07);
      rd(STAT_IDX, 8'h00);
      // Always-on: periodic clears hold off the reset
      @(posedge clk);
      mode <= 2'h3;
      wr(CTRL_IDX, 8'h00);
      for (int i = 0; i < 4; i++) begin
         kick();
         idle(400);
      end
      chk_lvl("active", 1'b1, active);
      kick();
      expect_evt(EV_RST, 600, 680);
      // Reserved codes act as the shortest period; code 1 doubles it
      wr(CTRL_IDX, 8'h26);
      kick();
      expect_evt(EV_RST, 600, 680);
      wr(CTRL_IDX, 8'h3E);
      kick();
      expect_evt(EV_RST, 600, 680);
      wr(CTRL_IDX, 8'h02);
      kick();
      expect_evt(EV_RST, 1240, 1320);
      // Sleep entry late in the count restarts it; expiry wakes
      wr(CTRL_IDX, 8'h00);
      kick();
      idle(400);
      sleep <= 1'b1;
      expect_evt(EV_WAKE, 600, 680);
      chk_lvl("to_n", 1'b0, to_n);
      chk_lvl("pd_n", 1'b0, pd_n);
      @(posedge clk);
      sleep <= 1'b0;
      mode <= 2'h2;
      wr(STAT_IDX, 8'h07);
      // Off-in-sleep mode: silent asleep, runs again once awake
      kick();
      @(posedge clk);
      sleep <= 1'b1;
      idle(900);
      chk_lvl("active", 1'b0, active);
      sleep <= 1'b0;
      expect_evt(EV_RST, 600, 680);
      // Soft mode keeps running through sleep
      @(posedge clk);
      mode <= 2'h1;
      wr(CTRL_IDX, 8'h01);
      kick();
      @(posedge clk);
      sleep <= 1'b1;
      expect_evt(EV_WAKE, 600, 680);
      // Crystal wake holds the count until the start-up timer ends
      @(posedge clk);
      mode <= 2'h3;
      xtal <= 1'b1;
      sleep <= 1'b0;
      wr(CTRL_IDX, 8'h00);
      kick();
      @(posedge clk);
      sleep <= 1'b1;
      idle(300);
      sleep <= 1'b0;
      osc_startup_timer <= 1'b1;
      idle(900);
      osc_startup_timer <= 1'b0;
      expect_evt(EV_RST, 600, 680);
      // Oscillator failure holds the count clear
      wr(CTRL_IDX, 8'h00);
      kick();
      @(posedge clk);
      fail <= 1'b1;
      idle(900);
      fail <= 1'b0;
      expect_evt(EV_RST, 600, 680);
      rd(CTRL_IDX, CTRL_RST);
      // Mid-run reset with flags set and enable written
      wr(CTRL_IDX, 8'h01);
      @(posedge clk);
      rstn <= 1'b0;
      idle(2);
      rstn <= 1'b1;
      rd(CTRL_IDX, CTRL_RST);
      rd(STAT_IDX, 8'h00);
      idle(10);
      end_sim();
   end
endmodule
